//--- rtl/tec_timer.sv
// module: sixteen-bit timer/event counter with compare, capture and two outputs
`timescale 1ns/1ps
module tec_timer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic count_enable_bit,
    input wire logic [3:0] clk_sel,
    input wire tec_pkg::tec_edge_e edge_sel,
    input wire logic clear_on_b,
    input wire logic [15:0] compare_reg_a,
    input wire logic [15:0] compare_reg_b,
    input wire tec_pkg::tec_out_ctl_s ctl_a,
    input wire tec_pkg::tec_out_ctl_s ctl_b,
    input wire logic shot_start_a,
    input wire logic shot_start_b,
    input wire logic wrap_clear,
    input wire logic ext_capture_input,
    output tec_pkg::tec_status_s status,
    output logic match_irq_a,
    output logic match_irq_b,
    output logic capture_irq,
    output logic timer_out_a,
    output logic timer_out_b
);
    // ------------------------------------------------------------
    // input synchroniser and edge detect
    // ------------------------------------------------------------
    logic sync1_reg, sync2_reg, sync3_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= ext_capture_input;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // valid edge from the selected polarity
    wire rise = sync2_reg & ~sync3_reg;
    wire fall = ~sync2_reg & sync3_reg;
    wire ext_edge = (edge_sel[0] & rise) | (edge_sel[1] & fall);

    // ------------------------------------------------------------
    // prescaler and count clock selection
    // ------------------------------------------------------------
    logic [9:0] pre_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) pre_reg <= tec_pkg::PRE_RESET;
        else pre_reg <= pre_reg + 10'h001;
    end

    // code n ticks once every 2^(n+1) clocks, when the low n+1 bits are all one
    wire [3:0] tap = clk_sel - tec_pkg::SEL_DIV4 + 4'h1;
    wire [10:0] ones_mask = (11'h002 << tap) - 11'h001;
    wire pre_tick = ((pre_reg & ones_mask[9:0]) == ones_mask[9:0]);
    wire sel_int = (clk_sel >= tec_pkg::SEL_DIV4) && (clk_sel <= tec_pkg::SEL_DIV1024);
    wire sel_ext = (clk_sel == tec_pkg::SEL_EXT);
    wire count_tick = (sel_int & pre_tick) | (sel_ext & ext_edge);

    // ------------------------------------------------------------
    // counter, first-tick clear, wrap flag
    // ------------------------------------------------------------
    logic [15:0] cnt_reg, cnt_next;
    logic run_reg, fresh_reg, wrap_reg;
    // a tick in the very cycle of the enable rise is still the clearing first tick
    wire first_pending = fresh_reg | (count_enable_bit & ~run_reg);
    wire match_a = run_reg & ~fresh_reg & (cnt_reg == compare_reg_a);
    wire match_b = run_reg & ~fresh_reg & (cnt_reg == compare_reg_b);
    wire wrap_now = count_enable_bit & run_reg & ~fresh_reg & count_tick
        & (cnt_reg == tec_pkg::CNT_MAX);
    logic match_a_d_reg, match_b_d_reg;
    wire match_a_rise = match_a & ~match_a_d_reg;
    wire match_b_rise = match_b & ~match_b_d_reg;

    // next count value
    always_comb begin
        cnt_next = cnt_reg;
        if (!count_enable_bit) cnt_next = tec_pkg::CNT_RESET;
        else if (count_tick && first_pending) cnt_next = tec_pkg::CNT_RESET;
        else if (count_tick && clear_on_b && match_b) cnt_next = tec_pkg::CNT_RESET;
        else if (count_tick) cnt_next = cnt_reg + 16'h0001;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reg <= tec_pkg::CNT_RESET;
            run_reg <= 1'b0;
            fresh_reg <= 1'b0;
            wrap_reg <= 1'b0;
            match_a_d_reg <= 1'b0;
            match_b_d_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= count_enable_bit;
            // clearing first tick stays armed until a count clock takes it
            fresh_reg <= count_enable_bit & first_pending & ~count_tick;
            if (wrap_now) wrap_reg <= 1'b1;
            else if (wrap_clear) wrap_reg <= 1'b0;
            match_a_d_reg <= match_a;
            match_b_d_reg <= match_b;
        end
    end

    // ------------------------------------------------------------
    // capture and interrupt requests
    // ------------------------------------------------------------
    logic [15:0] cap_reg;
    logic irq_a_reg, irq_b_reg, irq_c_reg;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cap_reg <= tec_pkg::CNT_RESET;
            irq_a_reg <= 1'b0;
            irq_b_reg <= 1'b0;
            irq_c_reg <= 1'b0;
        end else begin
            if (ext_edge && run_reg) cap_reg <= cnt_reg;
            irq_a_reg <= match_a_rise;
            irq_b_reg <= match_b_rise;
            irq_c_reg <= ext_edge;
        end
    end

    // ------------------------------------------------------------
    // output control per channel
    // ------------------------------------------------------------
    wire [1:0] out_bit;
    wire tec_pkg::tec_out_ctl_s ctl [2];
    wire [1:0] own_m = {match_b_rise, match_a_rise};
    wire [1:0] start = {shot_start_b, shot_start_a};
    assign ctl[0] = ctl_a;
    assign ctl[1] = ctl_b;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_out
            logic level_reg;
            // one-shot, pwm and toggle behaviour of one pin
            always_ff @(posedge clk) begin
                if (!rst_b) level_reg <= 1'b0;
                else if (ctl[gi].one_shot && start[gi]) level_reg <= 1'b1;
                else if (ctl[gi].one_shot && own_m[gi]) level_reg <= 1'b0;
                else if (ctl[gi].pwm_mode && match_a_rise) level_reg <= 1'b1;
                else if (ctl[gi].pwm_mode && match_b_rise) level_reg <= 1'b0;
                else if (ctl[gi].toggle_en && own_m[gi]) level_reg <= ~level_reg;
            end
            assign out_bit[gi] = level_reg;
        end
    endgenerate

    assign timer_out_a = ctl_a.enable ? out_bit[0] : ctl_a.idle_level;
    assign timer_out_b = ctl_b.enable ? out_bit[1] : ctl_b.idle_level;
    assign match_irq_a = irq_a_reg;
    assign match_irq_b = irq_b_reg;
    assign capture_irq = irq_c_reg;
    assign status = '{count: cnt_reg, capture: cap_reg, wrap: wrap_reg};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_wrap;
        wrap_now;
    endsequence
    property p_wrap_sticky;
        @(posedge clk) disable iff (!rst_b) s_wrap |=> wrap_reg && cnt_reg == 16'h0000;
    endproperty
    a_wrap_sticky: assert property (p_wrap_sticky) else $error("wrap not flagged");

    property p_wrap_hold;
        @(posedge clk) disable iff (!rst_b) wrap_reg && !wrap_clear |=> wrap_reg;
    endproperty
    a_wrap_hold: assert property (p_wrap_hold) else $error("wrap flag lost");

    property p_disable_zero;
        @(posedge clk) disable iff (!rst_b) !count_enable_bit |=> cnt_reg == 16'h0000;
    endproperty
    a_disable_zero: assert property (p_disable_zero) else $error("counter not zeroed");

    property p_first_clear;
        @(posedge clk) disable iff (!rst_b)
            first_pending && count_tick && count_enable_bit |=> cnt_reg == 16'h0000 && !fresh_reg;
    endproperty
    a_first_clear: assert property (p_first_clear) else $error("first tick not clear");

    property p_capture;
        @(posedge clk) disable iff (!rst_b) ext_edge && run_reg |=> cap_reg == $past(cnt_reg);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    property p_irq_a;
        @(posedge clk) disable iff (!rst_b) match_a_rise |=> match_irq_a ##1 !match_irq_a;
    endproperty
    a_irq_a: assert property (p_irq_a) else $error("irq a wrong");

    property p_irq_b;
        @(posedge clk) disable iff (!rst_b) match_irq_b |-> $past(match_b_rise);
    endproperty
    a_irq_b: assert property (p_irq_b) else $error("irq b spurious");

    property p_shot;
        @(posedge clk) disable iff (!rst_b) ctl_a.one_shot && shot_start_a |=> out_bit[0];
    endproperty
    a_shot: assert property (p_shot) else $error("one-shot not set");

    property p_sync;
        @(posedge clk) disable iff (!rst_b) ext_capture_input |-> ##2 sync2_reg;
    endproperty
    a_sync: assert property (p_sync) else $error("sync chain broken");
endmodule

//--- rtl/tec_pkg.sv
// package: constants and types for the sixteen-bit timer/event counter
package tec_pkg;
    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [9:0] PRE_RESET = 10'h000;
    localparam logic [3:0] CLK_SEL_RESET = 4'h1;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // count clock selection codes
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_DIV4 = 4'h1;
    localparam logic [3:0] SEL_DIV1024 = 4'h9;
    localparam logic [3:0] SEL_EXT = 4'hB;

    // ------------------------------------------------------------
    // external input timing, figures in fclk periods
    // ------------------------------------------------------------
    localparam int EXT_MIN_LEVEL_CLK = 3;
    localparam int EXT_MIN_PERIOD_CLK = 6;

    // ------------------------------------------------------------
    // edge selection for the external input
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TEC_EDGE_NONE = 2'b00,
        TEC_EDGE_RISE = 2'b01,
        TEC_EDGE_FALL = 2'b10,
        TEC_EDGE_BOTH = 2'b11
    } tec_edge_e;

    // per-output control bundle
    typedef struct packed {
        logic enable;      // pin follows the flip-flop when set
        logic idle_level;  // level shown while disabled
        logic toggle_en;   // compare match inverts the output
        logic pwm_mode;    // a match sets, b match resets
        logic one_shot;    // software sets, own match resets
    } tec_out_ctl_s;

    // status bundle
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] capture;
        logic wrap;
    } tec_status_s;
endpackage

//--- tb/tec_pin_src.sv
// partner model: pulse source on the external capture input pin
`timescale 1ns/1ps
module tec_pin_src (
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] half,
    output logic pin
);
    logic [3:0] cnt_reg;

    initial begin
        pin = 1'b0;
        cnt_reg = 4'h0;
    end

    // square wave, each level held for half cycles, at least three
    always @(posedge clk) begin
        if (!run) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg >= half - 4'h1) begin
            cnt_reg <= 4'h0;
            pin <= #1 ~pin;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule

//--- tb/sixteen_bit_timer_event_counter_tb.sv
// testbench: interval, event count, output and capture checks
`timescale 1ns/1ps
module sixteen_bit_timer_event_counter_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic en = 1'b0;
    logic [3:0] sel = tec_pkg::SEL_DIV4;
    tec_pkg::tec_edge_e edg = tec_pkg::TEC_EDGE_BOTH;
    logic clr_b = 1'b0;
    logic [15:0] cmp_a = 16'h0000;
    logic [15:0] cmp_b = 16'h0001;
    tec_pkg::tec_out_ctl_s ca = 5'h00;
    tec_pkg::tec_out_ctl_s cb = 5'h00;
    logic sa = 1'b0;
    logic sb = 1'b0;
    logic wclr = 1'b0;
    logic run = 1'b0;
    logic [3:0] half = 4'h3;
    logic pin, ia, ib, ic, oa, ob, oa_d, pin_d;
    logic [15:0] cap_d;
    tec_pkg::tec_status_s st;
    int errors = 0;
    int checks_done = 0;
    int now = 0, last_b = 0, n_edges = 0, n0, k;
    int n_rise = 0, n_cap = 0, r0, m;
    int exp_q[$];

    tec_timer tec_timer_i (.clk(clk), .rst_b(rst_b), .count_enable_bit(en), .clk_sel(sel),
        .edge_sel(edg), .clear_on_b(clr_b), .compare_reg_a(cmp_a), .compare_reg_b(cmp_b),
        .ctl_a(ca), .ctl_b(cb), .shot_start_a(sa), .shot_start_b(sb), .wrap_clear(wclr),
        .ext_capture_input(pin), .status(st), .match_irq_a(ia), .match_irq_b(ib),
        .capture_irq(ic), .timer_out_a(oa), .timer_out_b(ob));
    tec_pin_src tec_pin_src_i (.clk(clk), .run(run), .half(half), .pin(pin));

    task automatic final_report;
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("BAD at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    // bounded wait for a match b pulse, then one more edge
    task automatic wait_b;
        for (int i = 0; i < 5000; i++) begin
            @(posedge clk);
            #1;
            if (ib === 1'b1) begin
                @(posedge clk);
                #1;
                return;
            end
        end
        errors++;
        $display("BAD at %0t: no match b request in time", $time);
        final_report();
    endtask

    // clock
    initial begin
        forever #10 clk = ~clk;
    end

    // monitor: gap between match b pulses, toggle and pwm output, capture value and hold
    always @(posedge clk) begin
        now <= now + 1;
        oa_d <= oa;
        pin_d <= pin;
        cap_d <= st.capture;
        if (pin !== pin_d) n_edges <= n_edges + 1;
        if (pin === 1'b1 && pin_d === 1'b0) n_rise <= n_rise + 1;
        if (ib === 1'b1) begin
            if (exp_q.size() > 0) check(now - last_b, exp_q.pop_front());
            last_b <= now;
        end
        if (ia === 1'b1 && ca.enable && ca.toggle_en) check(oa, !oa_d);
        if (ia === 1'b1 && ca.enable && ca.pwm_mode) check(oa, 1'b1);
        if (ib === 1'b1 && ia !== 1'b1 && ca.enable && ca.pwm_mode) check(oa, 1'b0);
        if (ic !== 1'b1 && rst_b) check(st.capture, cap_d);
        if (ic === 1'b1) begin
            // the k-th valid edge captures k-2, the first one the cleared zero
            check(st.capture, (n_cap == 0) ? 0 : n_cap - 1);
            n_cap <= n_cap + 1;
        end
    end

    // main sequence
    initial begin
        k = $urandom(32'h24b412b3);
        repeat (12) @(posedge clk);
        #1 rst_b = 1'b1;
        check(st.count, 16'h0000);
        check(st.wrap, 1'b0);
        clr_b = 1'b1;
        ca = 5'h14;
        for (int s = 1; s <= 9; s++) begin
            sel = 4'(s);
            cmp_a = 16'($urandom_range(1, 0));
            en = 1'b1;
            wait_b();
            exp_q.push_back(2 << (s + 1));
            wait_b();
            en = 1'b0;
            @(posedge clk);
            #1;
            check(st.count, 16'h0000);
        end
        ca = 5'h09;
        cb = 5'h11;
        sel = tec_pkg::SEL_DIV4;
        en = 1'b1;
        wait_b();
        sa = 1'b1;
        sb = 1'b1;
        @(posedge clk);
        #1 sb = 1'b0;
        sa = 1'b0;
        check(ob, 1'b1);
        check(oa, 1'b1);
        wait_b();
        check(ob, 1'b0);
        en = 1'b0;
        clr_b = 1'b0;
        ca = 5'h12;
        sel = tec_pkg::SEL_EXT;
        if ($urandom_range(1, 0) == 1) edg = tec_pkg::TEC_EDGE_RISE;
        half = 4'(3 + $urandom_range(3, 0));
        wclr = 1'b1;
        @(posedge clk);
        #1 wclr = 1'b0;
        en = 1'b1;
        n0 = n_edges;
        r0 = n_rise;
        run = 1'b1;
        repeat (60) @(posedge clk);
        #1 run = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        m = (edg == tec_pkg::TEC_EDGE_BOTH) ? n_edges - n0 : n_rise - r0;
        check(st.count, m - 1);
        check(n_cap, m);
        check(st.wrap, 1'b0);
        final_report();
    end
endmodule
